// ==== hw/ota_pkg.sv ====
package ota_pkg;

   // ---------------------------------------------
   // Widths and channel layout
   // ---------------------------------------------
   localparam int unsigned OTA_NCH = 5;
   localparam int unsigned OTA_TEMP_W = 11;
   localparam int unsigned OTA_LIM_W = 8;
   localparam int unsigned OTA_FRAC_W = 3;
   localparam int unsigned OTA_CMP_W = 13;

   // Channel index equals status bit position
   localparam int unsigned OTA_CH_LOCAL = 0;
   localparam int unsigned OTA_CH_RMT1 = 1;
   localparam int unsigned OTA_CH_RMT2 = 2;
   localparam int unsigned OTA_CH_RMT3 = 3;
   localparam int unsigned OTA_CH_RMT4 = 4;

   // ---------------------------------------------
   // Command codes and reset values
   // ---------------------------------------------
   localparam logic [7:0] OTA_CMD_COMMON = 8'h02;
   localparam logic [7:0] OTA_CMD_STAT_A = 8'h08;
   localparam logic [7:0] OTA_CMD_STAT_B = 8'h09;
   localparam logic [7:0] OTA_CMD_MASK_A = 8'h0c;
   localparam logic [4:0] OTA_MASK_A_RST = 5'h19;
   localparam int unsigned OTA_COMMON_A_BIT = 1;
   localparam int unsigned OTA_COMMON_B_BIT = 2;

   // ---------------------------------------------
   // Carriers
   // ---------------------------------------------
   typedef struct packed {
      logic [OTA_NCH-1:0] valid;
      logic [OTA_NCH-1:0][OTA_TEMP_W-1:0] temp;
   } ota_conv_s;

   typedef struct packed {
      logic [OTA_LIM_W-1:0] local_lim;
      logic [OTA_LIM_W-1:0] rmt1_lim_a;
      logic [OTA_LIM_W-1:0] rmt2_lim_a;
      logic [OTA_LIM_W-1:0] rmt1_lim_b;
      logic [OTA_LIM_W-1:0] rmt2_lim_b;
      logic [OTA_LIM_W-1:0] rmt3_lim;
      logic [OTA_LIM_W-1:0] rmt4_lim;
      logic [OTA_LIM_W-1:0] hyst;
   } ota_limits_s;

   typedef struct packed {
      logic [7:0] cmd;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } ota_reg_req_s;

endpackage

// ==== hw/ota_status.sv ====
`timescale 1ns/1ps
module ota_status
   import ota_pkg::*;
(
   input wire logic clk_sys_in, // 20 MHz system clock
   input wire logic rst_in, // Synchronous reset, active high
   input wire ota_conv_s conv_in, // Conversion results with valid pulses
   input wire ota_limits_s limits_in, // Limits and shared hysteresis
   input wire ota_reg_req_s req_in, // Register command port
   output logic [7:0] rdata_out, // Read data
   output logic rvalid_out, // Read data valid pulse
   output logic overtemp_alarm_a_n_out, // First alarm, active low
   output logic overtemp_alarm_b_n_out // Second alarm, active low
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic [OTA_NCH-1:0] flag_a;
      logic [OTA_NCH-1:0] flag_b;
      logic [OTA_NCH-1:0] mask_a;
      logic [7:0] rdata;
      logic rvalid;
      logic alarm_a_n;
      logic alarm_b_n;
   } ota_state_s;

   ota_state_s st_reg;
   ota_state_s st_next;
   logic [OTA_NCH-1:0][OTA_LIM_W-1:0] lim_a;
   logic [OTA_NCH-1:0][OTA_LIM_W-1:0] lim_b;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Limits are whole degrees, readings carry three fraction bits
   function automatic logic signed [OTA_CMP_W-1:0] ota_scale(
      input logic signed [OTA_LIM_W:0] deg);
      ota_scale = OTA_CMP_W'(deg) <<< OTA_FRAC_W;
   endfunction

   // Hysteresis compare; the current flag holds inside the band
   function automatic logic ota_eval(
      input logic cur,
      input logic [OTA_TEMP_W-1:0] temp,
      input logic [OTA_LIM_W-1:0] lim,
      input logic [OTA_LIM_W-1:0] hyst);
      logic signed [OTA_CMP_W-1:0] t;
      logic signed [OTA_CMP_W-1:0] hi;
      logic signed [OTA_CMP_W-1:0] lo;
      t = OTA_CMP_W'(signed'(temp));
      hi = ota_scale(signed'({lim[OTA_LIM_W-1], lim}));
      lo = hi - ota_scale(signed'({1'b0, hyst}));
      if (t >= hi) begin
         ota_eval = 1'b1;
      end else if (t < lo) begin
         ota_eval = 1'b0;
      end else begin
         ota_eval = cur;
      end
   endfunction

   // Read decode for the read mux; unmapped codes read zero
   function automatic logic [7:0] ota_read(
      input logic [7:0] cmd,
      input ota_state_s s);
      case (cmd)
         OTA_CMD_STAT_A: ota_read = {3'h0, s.flag_a};
         OTA_CMD_STAT_B: ota_read = {3'h0, s.flag_b};
         OTA_CMD_MASK_A: ota_read = {3'h0, s.mask_a};
         OTA_CMD_COMMON: begin
            ota_read = 8'h00;
            ota_read[OTA_COMMON_A_BIT] = |s.flag_a;
            ota_read[OTA_COMMON_B_BIT] = |s.flag_b;
         end
         default: ota_read = 8'h00;
      endcase
   endfunction

   // ---------------------------------------------
   // Limit routing per channel
   // ---------------------------------------------
   // Local, remote 3 and remote 4 use one limit for both alarms
   always_comb begin
      lim_a = '0;
      lim_b = '0;
      lim_a[OTA_CH_LOCAL] = limits_in.local_lim;
      lim_b[OTA_CH_LOCAL] = limits_in.local_lim;
      lim_a[OTA_CH_RMT1] = limits_in.rmt1_lim_a;
      lim_b[OTA_CH_RMT1] = limits_in.rmt1_lim_b;
      lim_a[OTA_CH_RMT2] = limits_in.rmt2_lim_a;
      lim_b[OTA_CH_RMT2] = limits_in.rmt2_lim_b;
      lim_a[OTA_CH_RMT3] = limits_in.rmt3_lim;
      lim_b[OTA_CH_RMT3] = limits_in.rmt3_lim;
      lim_a[OTA_CH_RMT4] = limits_in.rmt4_lim;
      lim_b[OTA_CH_RMT4] = limits_in.rmt4_lim;
   end

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      // A flag moves only when its channel has a fresh result
      for (int i = 0; i < OTA_NCH; i++) begin
         if (conv_in.valid[i]) begin
            st_next.flag_a[i] = ota_eval(st_reg.flag_a[i], conv_in.temp[i],
                                         lim_a[i], limits_in.hyst);
            st_next.flag_b[i] = ota_eval(st_reg.flag_b[i], conv_in.temp[i],
                                         lim_b[i], limits_in.hyst);
         end
      end
      // Only the mask is writable; status writes are dropped
      if (req_in.wr && req_in.cmd == OTA_CMD_MASK_A) begin
         st_next.mask_a = req_in.wdata[OTA_NCH-1:0];
      end
      // Reads return state as it stood before this edge
      if (req_in.rd) begin
         st_next.rdata = ota_read(req_in.cmd, st_reg);
         st_next.rvalid = 1'b1;
      end
      // Pins follow the new flags so status and pin agree on reads
      st_next.alarm_a_n = ~|(st_next.flag_a & ~st_next.mask_a);
      st_next.alarm_b_n = ~|st_next.flag_b;
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         st_reg.flag_a <= '0;
         st_reg.flag_b <= '0;
         st_reg.mask_a <= OTA_MASK_A_RST;
         st_reg.rdata <= 8'h00;
         st_reg.rvalid <= 1'b0;
         st_reg.alarm_a_n <= 1'b1;
         st_reg.alarm_b_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flops
   assign rdata_out = st_reg.rdata;
   assign rvalid_out = st_reg.rvalid;
   assign overtemp_alarm_a_n_out = st_reg.alarm_a_n;
   assign overtemp_alarm_b_n_out = st_reg.alarm_b_n;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   // Helper: local reading at or over the local limit
   logic loc_hot;
   logic loc_cold;
   assign loc_hot = signed'(OTA_CMP_W'(signed'(conv_in.temp[OTA_CH_LOCAL])))
      >= ota_scale(signed'({limits_in.local_lim[OTA_LIM_W-1],
                            limits_in.local_lim}));
   assign loc_cold = signed'(OTA_CMP_W'(signed'(conv_in.temp[OTA_CH_LOCAL])))
      < ota_scale(signed'({limits_in.local_lim[OTA_LIM_W-1],
                           limits_in.local_lim}))
      - ota_scale(signed'({1'b0, limits_in.hyst}));

   property p_set_local;
      conv_in.valid[OTA_CH_LOCAL] && loc_hot |=>
         st_reg.flag_a[OTA_CH_LOCAL] && st_reg.flag_b[OTA_CH_LOCAL];
   endproperty
   a_set_local: assert property (p_set_local)
      else $error("local flag not set at limit");

   property p_hold_band;
      conv_in.valid[OTA_CH_LOCAL] && !loc_hot && !loc_cold |=>
         st_reg.flag_a[OTA_CH_LOCAL] == $past(st_reg.flag_a[OTA_CH_LOCAL]);
   endproperty
   a_hold_band: assert property (p_hold_band)
      else $error("local flag changed inside hysteresis band");

   property p_clear_local;
      conv_in.valid[OTA_CH_LOCAL] && loc_cold |=>
         !st_reg.flag_a[OTA_CH_LOCAL] && !st_reg.flag_b[OTA_CH_LOCAL];
   endproperty
   a_clear_local: assert property (p_clear_local)
      else $error("local flag not cleared below band");

   property p_no_update;
      conv_in.valid == '0 |=> $stable(st_reg.flag_a) && $stable(st_reg.flag_b);
   endproperty
   a_no_update: assert property (p_no_update)
      else $error("flags moved without a conversion");

   property p_alarm_a;
      overtemp_alarm_a_n_out == !(|(st_reg.flag_a & ~st_reg.mask_a));
   endproperty
   a_alarm_a: assert property (p_alarm_a)
      else $error("first alarm pin disagrees with unmasked flags");

   property p_alarm_b;
      overtemp_alarm_b_n_out == (st_reg.flag_b == '0);
   endproperty
   a_alarm_b: assert property (p_alarm_b)
      else $error("second alarm pin disagrees with flags");

   property p_read_a;
      req_in.rd && req_in.cmd == OTA_CMD_STAT_A |=>
         rvalid_out && rdata_out == {3'h0, $past(st_reg.flag_a)};
   endproperty
   a_read_a: assert property (p_read_a)
      else $error("first status read wrong");

   property p_read_b;
      req_in.rd && req_in.cmd == OTA_CMD_STAT_B |=>
         rvalid_out && rdata_out[7:5] == 3'h0
         && rdata_out[4:0] == $past(st_reg.flag_b);
   endproperty
   a_read_b: assert property (p_read_b)
      else $error("second status read wrong");

   property p_ro;
      req_in.wr && !req_in.rd && conv_in.valid == '0 |=>
         $stable(st_reg.flag_a) && $stable(st_reg.flag_b);
   endproperty
   a_ro: assert property (p_ro)
      else $error("status changed by a write");

   property p_shared_lim;
      conv_in.valid[OTA_CH_RMT3] |=>
         st_reg.flag_a[OTA_CH_RMT3] == st_reg.flag_b[OTA_CH_RMT3];
   endproperty
   a_shared_lim: assert property (p_shared_lim)
      else $error("remote 3 flags disagree under one limit");

   property p_mask_wr;
      req_in.wr && req_in.cmd == OTA_CMD_MASK_A ##1 req_in.rd
         && req_in.cmd == OTA_CMD_MASK_A |=>
         rdata_out == {3'h0, $past(req_in.wdata[4:0], 2)};
   endproperty
   a_mask_wr: assert property (p_mask_wr)
      else $error("mask write not read back");

   property p_common;
      req_in.rd && req_in.cmd == OTA_CMD_COMMON |=>
         rdata_out[OTA_COMMON_A_BIT] == |$past(st_reg.flag_a)
         && rdata_out[OTA_COMMON_B_BIT] == |$past(st_reg.flag_b);
   endproperty
   a_common: assert property (p_common)
      else $error("summary flags wrong");

   property p_common_rsv;
      req_in.rd && req_in.cmd == OTA_CMD_COMMON |=>
         rdata_out[7:3] == 5'h00 && !rdata_out[0];
   endproperty
   a_common_rsv: assert property (p_common_rsv)
      else $error("summary register spare bits not zero");

   property p_read_mask;
      req_in.rd && req_in.cmd == OTA_CMD_MASK_A |=>
         rvalid_out && rdata_out == {3'h0, $past(st_reg.mask_a)};
   endproperty
   a_read_mask: assert property (p_read_mask)
      else $error("mask read wrong");

   // A read answer is a single pulse; nothing answers an idle port
   property p_rvalid_idle;
      !req_in.rd |=> !rvalid_out;
   endproperty
   a_rvalid_idle: assert property (p_rvalid_idle)
      else $error("read valid without a read");

   // Helper: remote 1 at or over its own second-alarm limit
   logic rmt1_hot_b;
   assign rmt1_hot_b = signed'(OTA_CMP_W'(signed'(conv_in.temp[OTA_CH_RMT1])))
      >= ota_scale(signed'({limits_in.rmt1_lim_b[OTA_LIM_W-1],
                            limits_in.rmt1_lim_b}));

   property p_set_rmt1_b;
      conv_in.valid[OTA_CH_RMT1] && rmt1_hot_b |=> st_reg.flag_b[OTA_CH_RMT1];
   endproperty
   a_set_rmt1_b: assert property (p_set_rmt1_b)
      else $error("remote 1 second flag not set at its own limit");

   // Remote 4 has one limit, so its two flags can never part
   property p_shared_rmt4;
      conv_in.valid[OTA_CH_RMT4] |=>
         st_reg.flag_a[OTA_CH_RMT4] == st_reg.flag_b[OTA_CH_RMT4];
   endproperty
   a_shared_rmt4: assert property (p_shared_rmt4)
      else $error("remote 4 flags disagree under one limit");

endmodule

// ==== testbench/ota_alarm_watch.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// System alarm watcher
// ---------------------------------------------
module ota_alarm_watch (
   input wire logic alarm_a_n_in, // First alarm pin, active low
   input wire logic alarm_b_n_in, // Second alarm pin, active low
   output logic alarm_a_act_out, // First alarm seen active
   output logic alarm_b_act_out // Second alarm seen active
);
   // Plain level reading, no filter, so any glitch on a pin shows up
   assign alarm_a_act_out = ~alarm_a_n_in;
   assign alarm_b_act_out = ~alarm_b_n_in;
endmodule

// ==== testbench/ota_status_tb.sv ====
`timescale 1ns/1ps
module ota_status_tb;
   import ota_pkg::*;
   // ---------------------------------------------
   // Stimulus, design and watcher
   // ---------------------------------------------
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   ota_conv_s conv_in = '0;
   ota_limits_s limits_in = '0;
   ota_reg_req_s req_in = '0;
   logic [7:0] rdata_out;
   logic rvalid_out;
   logic overtemp_alarm_a_n_out;
   logic overtemp_alarm_b_n_out;
   logic alarm_a_act;
   logic alarm_b_act;
   int fail_count = 0;
   int checks_done = 0;
   int lim_a[5];
   int lim_b[5];
   int fa = 0;
   int fb = 0;
   int mask = 'h19;
   int hyst;
   always #25 clk_sys_in = ~clk_sys_in;
   ota_status i_ota_status (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .conv_in(conv_in),
      .limits_in(limits_in), .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
      .overtemp_alarm_a_n_out(overtemp_alarm_a_n_out),
      .overtemp_alarm_b_n_out(overtemp_alarm_b_n_out));
   ota_alarm_watch i_ota_alarm_watch (.alarm_a_n_in(overtemp_alarm_a_n_out),
      .alarm_b_n_in(overtemp_alarm_b_n_out), .alarm_a_act_out(alarm_a_act),
      .alarm_b_act_out(alarm_b_act));
   // ---------------------------------------------
   // Shared tasks; all are entered just after a falling edge
   // ---------------------------------------------
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic reg_rd(logic [7:0] cmd, logic [7:0] exp);
      req_in.cmd = cmd;
      req_in.rd = 1'b1;
      @(negedge clk_sys_in);
      req_in.rd = 1'b0;
      check("rvalid", {7'h0, rvalid_out}, 8'h01);
      check("rdata", rdata_out, exp);
      @(negedge clk_sys_in);
      check("rvalid_drop", {7'h0, rvalid_out}, 8'h00);
   endtask
   task automatic reg_wr(logic [7:0] cmd, logic [7:0] d);
      req_in.cmd = cmd;
      req_in.wdata = d;
      req_in.wr = 1'b1;
      @(negedge clk_sys_in);
      req_in.wr = 1'b0;
      if (cmd == OTA_CMD_MASK_A) mask = d & 'h1f;
   endtask
   // Reference comparator with a hold band between the two thresholds
   function automatic int upd(int cur, int t, int l);
      if (t >= l * 8) return 1;
      if (t < (l - hyst) * 8) return 0;
      return cur;
   endfunction
   task automatic pins();
      check("alarm_a_n", {7'h0, overtemp_alarm_a_n_out}, {7'h0, (fa & ~mask) == 0});
      check("alarm_b_n", {7'h0, overtemp_alarm_b_n_out}, {7'h0, fb == 0});
      check("watch_a", {7'h0, alarm_a_act}, {7'h0, (fa & ~mask) != 0});
      check("watch_b", {7'h0, alarm_b_act}, {7'h0, fb != 0});
   endtask
   // Every channel gets a new reading, but only flagged ones are taken
   task automatic conv(int v);
      int t;
      for (int c = 0; c < 5; c++) begin
         // Centre on the hold band below either limit, so the second limits of remotes 1 and 2 are crossed too
         t = (($urandom % 2) ? lim_b[c] : lim_a[c]) * 8
            + int'($urandom % (hyst * 8 + 48)) - hyst * 8 - 24;
         conv_in.temp[c] = t[10:0];
         if (v[c]) begin
            fa = upd(fa[c], t, lim_a[c]) ? fa | (1 << c) : fa & ~(1 << c);
            fb = upd(fb[c], t, lim_b[c]) ? fb | (1 << c) : fb & ~(1 << c);
         end
      end
      conv_in.valid = v[4:0];
      @(negedge clk_sys_in);
      conv_in.valid = '0;
      @(negedge clk_sys_in);
      pins();
   endtask
   // ---------------------------------------------
   // Watchdog, well beyond the roughly 700 cycles of the tests
   // ---------------------------------------------
   initial begin
      #(20000 * 50);
      fail_count++;
      close_out();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(32'hf5e5));
      hyst = 1 + $urandom % 7; // Nonzero, so a hold band always exists
      for (int c = 0; c < 5; c++) lim_a[c] = 20 + $urandom % 70;
      lim_b = lim_a;
      lim_b[1] = lim_a[1] + 3;
      lim_b[2] = lim_a[2] - 4;
      limits_in = '{8'(lim_a[0]), 8'(lim_a[1]), 8'(lim_a[2]), 8'(lim_b[1]), 8'(lim_b[2]),
         8'(lim_a[3]), 8'(lim_a[4]), 8'(hyst)};
      repeat (20) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      rst_in = 1'b0;
      reg_rd(OTA_CMD_MASK_A, 8'h19);
      reg_rd(OTA_CMD_STAT_A, 8'h00);
      pins();
      $display("reset test done");
      // Random readings around each threshold, with mask changes and reads
      for (int i = 0; i < 80; i++) begin
         conv($urandom % 32);
         if (i % 8 == 7) reg_wr(OTA_CMD_MASK_A, 8'($urandom));
         if (i % 8 == 3) reg_wr(OTA_CMD_STAT_A, 8'hff);
         pins();
         reg_rd(OTA_CMD_STAT_A, fa[7:0]);
         reg_rd(OTA_CMD_STAT_B, fb[7:0]);
         reg_rd(OTA_CMD_COMMON, {5'h0, fb != 0, fa != 0, 1'b0});
      end
      $display("threshold test done");
      reg_wr(OTA_CMD_MASK_A, 8'he6);
      reg_rd(OTA_CMD_MASK_A, 8'h06);
      reg_rd(8'h0d, 8'h00);
      conv(5'h1f);
      pins();
      $display("mask test done");
      close_out();
   end
endmodule
